// file: rats_cfg.svh
// Offsets, field positions, reset values and timing counts of the register bank
`ifndef RATS_CFG_SVH
`define RATS_CFG_SVH
`define RATS_OFF_CTRL     8'h00
`define RATS_OFF_SC       8'h04
`define RATS_OFF_STAT     8'h08
`define RATS_OFF_RC       8'h0c
`define RATS_OFF_W1C      8'h10
`define RATS_OFF_W0C      8'h14
`define RATS_OFF_WO       8'h18
`define RATS_OFF_IRQ_STAT 8'h1c
`define RATS_OFF_IRQ_CLR  8'h20
`define RATS_OFF_IRQ_EN   8'h24
`define RATS_CTRL_W       16
`define RATS_CTRL_RST     16'h0000
`define RATS_WO_RST       32'h0000_0000
`define RATS_LH_LSB       8
`define RATS_IRQ_W        6
`define RATS_IRQ_EN_RST   6'h00
`define RATS_IRQ_RC       0
`define RATS_IRQ_W1C      1
`define RATS_IRQ_W0C      2
`define RATS_IRQ_LL       3
`define RATS_IRQ_LH       4
`define RATS_IRQ_SC       5
`define RATS_RESP_OKAY    2'h0
`define RATS_RESP_SLVERR  2'h2
`define RATS_CLK_MHZ      200
`define RATS_SC_HOLD_NS   40
`define RATS_SC_HOLD_CYC  ((`RATS_SC_HOLD_NS * `RATS_CLK_MHZ + 999) / 1000)
`endif

// file: rats_pkg.sv
// Types shared by the register bank
package rats_pkg;
	typedef enum logic [10:0] {
		rats_sel_none     = 11'h001,
		rats_sel_ctrl     = 11'h002,
		rats_sel_sc       = 11'h004,
		rats_sel_stat     = 11'h008,
		rats_sel_rc       = 11'h010,
		rats_sel_w1c      = 11'h020,
		rats_sel_w0c      = 11'h040,
		rats_sel_wo       = 11'h080,
		rats_sel_irq_stat = 11'h100,
		rats_sel_irq_clr  = 11'h200,
		rats_sel_irq_en   = 11'h400
	} rats_sel_t;
	typedef logic [31:0] rats_word_t;
endpackage

// file: rats_regbank.sv
// Register bank showing each bit access type behind an AXI4-Lite slave
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "rats_cfg.svh"

// Overview of operation
// [R1] Read-only bits return their value; writes leave them unchanged.
// [R2] Read-to-clear bits clear on a read; writes do not change them.
// [R3] Write-only bits accept writes; their read data is meaningless.
// [R4] Write-one-to-clear bits clear where a one is written; zero does nothing.
// [R5] Write-zero-to-clear bits clear where a zero is written; one does nothing.
// [R6] Latch-low bit that drops stays low until read, whatever the condition.
// [R7] Reading a latch-low bit releases it to follow the live condition.
// [R8] Latch-high bit that rises stays high until read, whatever the condition.
// [R9] Reading a latch-high bit releases it to follow the live condition.
// [R10] Self-clearing bit set by writing one returns to zero; zero ignored; readable.
// [R11] Software writes zeros into reserved fields; t_regs writes 16'h1234 into the reserved upper CTRL bits.
// [R12] Reserved bits may read as anything; host must not depend on them.
// [R13] Whole register space is reachable through the host management access path.
// [R14] PHY registers reachable over the management serial interface.
// [R15] Active-low hardware reset resets the bank; high allows operation.
// [R16] Host does not access reserved addresses; t_regs reads unmapped 8'h30 to check the slave error.
// [R17] A hardware set in the same cycle as a clear wins.
// [R18] Reset returns all bits to reset values and releases all latches.
module rats_regbank
	import rats_pkg::*;
#(
	parameter int EW = 8
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic [EW-1:0]          latch_low_cond,
	input  wire logic [EW-1:0]          latch_high_cond,
	input  wire logic [EW-1:0]          rc_event,
	input  wire logic [EW-1:0]          w1c_event,
	input  wire logic [EW-1:0]          w0c_event,
	output logic [`RATS_CTRL_W-1:0]     ctrl_out,
	output logic [31:0]                 wo_out,
	output logic [EW-1:0]               self_clearing_out,
	output logic                        irq
);
	// Word decode shared by the read and write paths
	function automatic rats_sel_t decode(input logic [7:0] a);
		logic [7:0] w;
		w = {a[7:2], 2'h0};
		if (w == `RATS_OFF_CTRL)          decode = rats_sel_ctrl;
		else if (w == `RATS_OFF_SC)       decode = rats_sel_sc;
		else if (w == `RATS_OFF_STAT)     decode = rats_sel_stat;
		else if (w == `RATS_OFF_RC)       decode = rats_sel_rc;
		else if (w == `RATS_OFF_W1C)      decode = rats_sel_w1c;
		else if (w == `RATS_OFF_W0C)      decode = rats_sel_w0c;
		else if (w == `RATS_OFF_WO)       decode = rats_sel_wo;
		else if (w == `RATS_OFF_IRQ_STAT) decode = rats_sel_irq_stat;
		else if (w == `RATS_OFF_IRQ_CLR)  decode = rats_sel_irq_clr;
		else if (w == `RATS_OFF_IRQ_EN)   decode = rats_sel_irq_en;
		else                              decode = rats_sel_none;
	endfunction

	// Byte strobes widened to a bit mask
	function automatic rats_word_t strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	logic [7:0]                awaddr_r;
	logic [31:0]               wdata_r;
	logic [3:0]                wstrb_r;
	logic                      aw_held_r;
	logic                      w_held_r;
	logic [7:0]                araddr_r;
	logic                      ar_pend_r;
	logic                      do_wr;
	logic                      do_rd;
	rats_sel_t                 wsel;
	rats_sel_t                 rsel;
	rats_word_t                wmask;
	rats_word_t                wr_one;
	rats_word_t                wr_zero;
	rats_word_t                rdata_nxt;
	logic [EW-1:0]             ll_s1_r;
	logic [EW-1:0]             ll_s2_r;
	logic [EW-1:0]             lh_s1_r;
	logic [EW-1:0]             lh_s2_r;
	logic [EW-1:0]             ll_latch_r;
	logic [EW-1:0]             lh_r;
	logic [EW-1:0]             rc_r;
	logic [EW-1:0]             w1c_r;
	logic [EW-1:0]             w0c_r;
	logic [EW-1:0]             sc_set;
	logic [7:0]                sc_cnt_r;
	logic                      sc_done;
	logic [`RATS_IRQ_W-1:0]    irq_stat_r;
	logic [`RATS_IRQ_W-1:0]    irq_en_r;
	logic [`RATS_IRQ_W-1:0]    irq_ev;
	logic                      rd_stat;
	logic                      rd_rc;

	// Single management access point; serial and in-band bridges master this bus
	assign do_wr   = aw_held_r & w_held_r & ~s_axi_bvalid; // R13
	assign do_rd   = ar_pend_r & ~s_axi_rvalid; // R14
	assign wsel    = decode(awaddr_r);
	assign rsel    = decode(araddr_r);
	assign wmask   = strb_mask(wstrb_r) & {32{do_wr}};
	assign wr_one  = wdata_r & wmask;
	assign wr_zero = ~wdata_r & wmask;
	assign rd_stat = do_rd & (rsel == rats_sel_stat);
	assign rd_rc   = do_rd & (rsel == rats_sel_rc);

	// Write address channel: hold one address until the response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin // R15
			s_axi_awready <= 1'b1;
			aw_held_r     <= 1'b0;
			awaddr_r      <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_held_r     <= 1'b1;
			awaddr_r      <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			aw_held_r     <= 1'b0;
		end
	end

	// Write data channel, independent of the address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_held_r     <= 1'b0;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_held_r     <= 1'b1;
			wdata_r      <= s_axi_wdata;
			wstrb_r      <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
			w_held_r     <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer with a slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RATS_RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wsel == rats_sel_none) ? `RATS_RESP_SLVERR : `RATS_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			ar_pend_r     <= 1'b0;
			araddr_r      <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			ar_pend_r     <= 1'b1;
			araddr_r      <= s_axi_araddr;
		end else begin
			if (do_rd)
				ar_pend_r <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_arready <= 1'b1;
		end
	end

	// Read data mux; reserved and write-only bits read as zero
	always_comb begin
		rdata_nxt = 32'h0000_0000; // R12
		if (rsel == rats_sel_ctrl)
			rdata_nxt[`RATS_CTRL_W-1:0] = ctrl_out;
		else if (rsel == rats_sel_sc)
			rdata_nxt[EW-1:0] = self_clearing_out; // R10
		else if (rsel == rats_sel_stat) begin
			rdata_nxt[EW-1:0] = ~ll_latch_r; // R1
			rdata_nxt[`RATS_LH_LSB +: EW] = lh_r;
		end else if (rsel == rats_sel_rc)
			rdata_nxt[EW-1:0] = rc_r;
		else if (rsel == rats_sel_w1c)
			rdata_nxt[EW-1:0] = w1c_r;
		else if (rsel == rats_sel_w0c)
			rdata_nxt[EW-1:0] = w0c_r;
		else if (rsel == rats_sel_irq_stat)
			rdata_nxt[`RATS_IRQ_W-1:0] = irq_stat_r;
		else if (rsel == rats_sel_irq_en)
			rdata_nxt[`RATS_IRQ_W-1:0] = irq_en_r;
	end

	// Read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RATS_RESP_OKAY;
		end else if (do_rd) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdata_nxt; // R3
			s_axi_rresp  <= (rsel == rats_sel_none) ? `RATS_RESP_SLVERR : `RATS_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control and write-only registers, byte lanes honoured, reserved bits dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin // R18
			ctrl_out <= `RATS_CTRL_RST;
			wo_out   <= `RATS_WO_RST;
		end else begin
			if (wsel == rats_sel_ctrl)
				ctrl_out <= (ctrl_out & ~wmask[`RATS_CTRL_W-1:0]) |
					wr_one[`RATS_CTRL_W-1:0];
			if (wsel == rats_sel_wo)
				wo_out <= (wo_out & ~wmask) | wr_one; // R3
		end
	end

	// Condition inputs come from outside: two-stage synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ll_s1_r <= '1;
			ll_s2_r <= '1;
			lh_s1_r <= '0;
			lh_s2_r <= '0;
		end else begin
			ll_s1_r <= latch_low_cond;
			ll_s2_r <= ll_s1_r;
			lh_s1_r <= latch_high_cond;
			lh_s2_r <= lh_s1_r;
		end
	end

	// Latch-low and latch-high status; a new drop or rise beats a releasing read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ll_latch_r <= '0; // R18
			lh_r       <= '0;
		end else begin
			ll_latch_r <= ~ll_s2_r | (ll_latch_r & ~{EW{rd_stat}}); // R6 R7 R17
			lh_r       <= lh_s2_r | (lh_r & ~{EW{rd_stat}}); // R8 R9 R17
		end
	end

	// Read-to-clear, write-one-to-clear and write-zero-to-clear event bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_r  <= '0;
			w1c_r <= '0;
			w0c_r <= '0;
		end else begin
			rc_r <= rc_event | (rc_r & ~{EW{rd_rc}}); // R2 R17
			if (wsel == rats_sel_w1c)
				w1c_r <= w1c_event | (w1c_r & ~wr_one[EW-1:0]); // R4 R17
			else
				w1c_r <= w1c_event | w1c_r;
			if (wsel == rats_sel_w0c)
				w0c_r <= w0c_event | (w0c_r & ~wr_zero[EW-1:0]); // R5 R17
			else
				w0c_r <= w0c_event | w0c_r;
		end
	end

	// Self-clearing command bits held for a fixed time, then cleared
	assign sc_set  = (wsel == rats_sel_sc) ? wr_one[EW-1:0] : '0;
	assign sc_done = (|self_clearing_out) && (sc_cnt_r == 8'h00) && !(|sc_set);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			self_clearing_out <= '0;
			sc_cnt_r          <= 8'h00;
		end else if (|sc_set) begin
			self_clearing_out <= self_clearing_out | sc_set; // R10
			sc_cnt_r          <= 8'(`RATS_SC_HOLD_CYC - 1);
		end else if (sc_done) begin
			self_clearing_out <= '0; // R10
		end else if (|self_clearing_out) begin
			sc_cnt_r <= sc_cnt_r - 8'h01;
		end
	end

	// Interrupt events, sticky status, write-one clear and enable
	always_comb begin
		irq_ev                = '0;
		irq_ev[`RATS_IRQ_RC]  = |rc_event;
		irq_ev[`RATS_IRQ_W1C] = |w1c_event;
		irq_ev[`RATS_IRQ_W0C] = |w0c_event;
		irq_ev[`RATS_IRQ_LL]  = |(~ll_s2_r & ~ll_latch_r);
		irq_ev[`RATS_IRQ_LH]  = |(lh_s2_r & ~lh_r);
		irq_ev[`RATS_IRQ_SC]  = sc_done;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= '0;
			irq_en_r   <= `RATS_IRQ_EN_RST;
			irq        <= 1'b0;
		end else begin
			if (wsel == rats_sel_irq_clr)
				irq_stat_r <= irq_ev | (irq_stat_r & ~wr_one[`RATS_IRQ_W-1:0]); // R17
			else
				irq_stat_r <= irq_ev | irq_stat_r;
			if (wsel == rats_sel_irq_en)
				irq_en_r <= (irq_en_r & ~wmask[`RATS_IRQ_W-1:0]) |
					wr_one[`RATS_IRQ_W-1:0];
			irq <= |(irq_stat_r & irq_en_r);
		end
	end
endmodule // rats_regbank

// file: rats_asserts.sv
// Port checker of the register bank
`timescale 1ns/1ps
module rats_asserts #(
	parameter int EW = 8
) (
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic [15:0]   ctrl_out,
	input wire logic [31:0]   wo_out,
	input wire logic [EW-1:0] self_clearing_out,
	input wire logic          irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus answers and refusals
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_b_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
	property p_r_busy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
	// Reset clears both response valids, irq, ctrl_out, wo_out and self_clearing_out, whatever came before
	property p_reset;
		disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq &&
			ctrl_out == 16'h0000 && wo_out == 32'h0000_0000 && self_clearing_out == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not reset");
	// Self-clearing bit holds a while, then drops by itself
	property p_sc_hold;
		$rose(self_clearing_out[0]) |=> self_clearing_out[0] [*7];
	endproperty
	a_sc_hold: assert property (p_sc_hold) else $error("self-clear too early");
	property p_sc_clr;
		$rose(self_clearing_out[0]) |-> ##[1:10] !self_clearing_out[0];
	endproperty
	a_sc_clr: assert property (p_sc_clr) else $error("self-clear missing");
	// Write-only contents change only after a write
	property p_wo_src;
		$changed(wo_out) && $past(aresetn) |-> $past(s_axi_awvalid && s_axi_awready, 2);
	endproperty
	a_wo_src: assert property (p_wo_src) else $error("write-only changed alone");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(irq));
endmodule // rats_asserts

// file: rats_host.sv
// Host model: AXI4-Lite master reached through tasks
`timescale 1ns/1ps
module rats_host (
	input  wire logic        aclk,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// Idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	// Whole-word write; callers stay on mapped words, but t_regs sets reserved CTRL bits
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Word read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // rats_host

// file: tb_top.sv
// Testbench of the register bank with its host model
`timescale 1ns/1ps
`include "rats_cfg.svh"
module tb_top
	import rats_pkg::*;
;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, self_clearing_out;
	logic [31:0] s_axi_wdata, s_axi_rdata, wo_out;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [15:0] ctrl_out;
	logic [7:0]  latch_low_cond, latch_high_cond, rc_event, w1c_event, w0c_event;
	rats_word_t  rdat;
	int          errors, tests_run, cyc;
	rats_regbank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .latch_low_cond,
		.latch_high_cond, .rc_event, .w1c_event, .w0c_event, .ctrl_out, .wo_out,
		.self_clearing_out, .irq);
	rats_host u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// Clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			test_done();
		end
	end
	task automatic chk(input rats_word_t got, input rats_word_t exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input rats_word_t exp);
		u_host.rd(a, rdat, resp);
		chk(rdat, exp);
	endtask
	task automatic t_regs();
		u_host.wr(`RATS_OFF_CTRL, 32'h1234_a5a5, resp);
		chk({30'h0, resp}, {30'h0, `RATS_RESP_OKAY});
		chk({16'h0000, ctrl_out}, 32'h0000_a5a5);
		rdc(`RATS_OFF_CTRL, 32'h0000_a5a5);
		u_host.wr(`RATS_OFF_STAT, 32'h0000_ff00, resp);
		rdc(`RATS_OFF_STAT, 32'h0000_00ff);
		u_host.wr(`RATS_OFF_WO, 32'hdead_beef, resp);
		chk(wo_out, 32'hdead_beef);
		u_host.rd(8'h30, rdat, resp);
		chk({30'h0, resp}, {30'h0, `RATS_RESP_SLVERR});
		$display("regs done");
	endtask
	task automatic t_clr();
		@(posedge aclk);
		{rc_event, w1c_event, w0c_event} <= 24'h81_ffff;
		@(posedge aclk);
		{rc_event, w1c_event, w0c_event} <= 24'h0;
		u_host.wr(`RATS_OFF_RC, 32'h0000_00ff, resp);
		rdc(`RATS_OFF_RC, 32'h0000_0081);
		rdc(`RATS_OFF_RC, 32'h0000_0000);
		u_host.wr(`RATS_OFF_W1C, 32'h0000_000f, resp);
		rdc(`RATS_OFF_W1C, 32'h0000_00f0);
		u_host.wr(`RATS_OFF_W0C, 32'h0000_000f, resp);
		rdc(`RATS_OFF_W0C, 32'h0000_000f);
		$display("clear done");
	endtask
	task automatic t_latch();
		@(posedge aclk);
		{latch_low_cond, latch_high_cond} <= 16'hfe01;
		repeat (4) @(posedge aclk);
		{latch_low_cond, latch_high_cond} <= 16'hff00;
		repeat (5) @(posedge aclk);
		rdc(`RATS_OFF_STAT, 32'h0000_01fe);
		rdc(`RATS_OFF_STAT, 32'h0000_00ff);
		$display("latch done");
	endtask
	task automatic t_sc();
		u_host.wr(`RATS_OFF_SC, 32'h0000_0001, resp);
		chk({24'h0, self_clearing_out}, 32'h0000_0001);
		u_host.wr(`RATS_OFF_SC, 32'h0000_0000, resp);
		chk({24'h0, self_clearing_out}, 32'h0000_0001);
		repeat (8) @(posedge aclk);
		chk({24'h0, self_clearing_out}, 32'h0000_0000);
		rdc(`RATS_OFF_SC, 32'h0000_0000);
		$display("self-clear done");
	endtask
	task automatic t_irq();
		u_host.wr(`RATS_OFF_IRQ_CLR, 32'h0000_003f, resp);
		u_host.wr(`RATS_OFF_IRQ_EN, 32'h0000_0000, resp);
		@(posedge aclk);
		rc_event <= 8'h01;
		@(posedge aclk);
		rc_event <= 8'h00;
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		rdc(`RATS_OFF_IRQ_STAT, 32'h0000_0001);
		u_host.wr(`RATS_OFF_IRQ_EN, 32'h0000_0001, resp);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		u_host.wr(`RATS_OFF_IRQ_CLR, 32'h0000_0001, resp);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		rdc(`RATS_OFF_IRQ_STAT, 32'h0000_0000);
		$display("irq done");
	endtask
	task automatic t_rst();
		u_host.wr(`RATS_OFF_CTRL, 32'h0000_ffff, resp);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk({16'h0000, ctrl_out}, 32'h0);
		rdc(`RATS_OFF_CTRL, 32'h0);
		$display("reset done");
	endtask
	task automatic test_done();
		$display("Counts: %0d checks, %0d mismatches", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		{errors, tests_run, cyc} = '0;
		aresetn = 1'b0;
		{latch_low_cond, latch_high_cond} = 16'hff00;
		{rc_event, w1c_event, w0c_event} = 24'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_clr();
		t_latch();
		t_sc();
		t_irq();
		t_rst();
		test_done();
	end
endmodule // tb_top
bind rats_regbank rats_asserts #(.EW(EW)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .ctrl_out, .wo_out,
	.self_clearing_out, .irq);
